// ===== hw/servo_status_output_mapper.sv
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
// Operation
// - Code 1: ready and no fault or alarm
// - Code 2: high while control power present
// - Code 3: speed at or below zero range
// - Code 4: speed has reached target speed
// - Code 5: pulse mode error within tolerance
// - Internal mode: position within plus-minus tolerance
// - Code 6: parameter or analog torque limit reached
// - Code 7: any fault; warning leads listed faults
// - Code 11: limits, stop, comm, undervoltage warning
// - Code 8: brake release timed by delays
// - Code 9: home sensor seen, conditions met
// - Code 10: overload beyond scaled permissible time
// - Full overload time raises alarm and fault
// - Code 12: internal command done after delay
// - Slot code zero disables that output
module servo_status_output_mapper
  import servo_dout_pkg::*;
#(
  parameter int unsigned TICK_PERIOD = TICK_CYCLES
)
(
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Drive state from internal logic
  input wire logic drive_ready,
  input wire logic control_power,
  input wire logic [15:0] motor_speed,
  input wire logic external_pulse_mode,
  input wire logic internal_position_mode,
  input wire logic [15:0] pulse_error,
  input wire logic signed [31:0] position_offset,
  input wire logic torque_param_limit_hit,
  input wire logic torque_analog_limit_hit,
  input wire logic other_fault,
  input wire logic [4:0] warn_conditions,
  input wire logic servo_on,
  input wire logic home_sensor_pin,
  input wire logic homing_conditions_met,
  input wire logic motor_overloaded,
  input wire logic internal_cmd_finished,
  // Outputs
  output logic [SLOTS-1:0] output_slots,
  output logic overload_alarm_code,
  output logic irq
);

  // Configuration registers
  logic [15:0] zero_speed_range; // Zero speed band, r/min
  logic [15:0] target_speed_setting; // Target speed, r/min
  logic [15:0] position_tolerance; // Position band, pulses
  logic [7:0] overload_warn_level; // Percent of permissible time
  logic [15:0] overload_time; // Permissible overload time, ticks
  logic [15:0] cmd_done_delay; // Command done delay, ticks
  logic [15:0] brake_on_delay; // Servo on to brake release, ticks
  logic [15:0] brake_off_delay; // Servo off to brake engage, ticks
  logic [19:0] slot_select; // Five 4-bit function codes
  logic [IRQ_W-1:0] irq_status; // Sticky event bits
  logic [IRQ_W-1:0] irq_mask; // Enables onto irq

  // Status functions, bit n is code n
  logic [FUNCS:1] func_state;

  // Select one function by code; zero and unused codes read low
  function automatic logic pick(input logic [3:0] code, input logic [FUNCS:1] f);
    logic hit;
    hit = 1'b0;
    if (code != FN_OFF && code <= FN_LAST)
      hit = f[code];
    return hit;
  endfunction

  // Millisecond enable
  logic tick;
  tick_divider #(.PERIOD(TICK_PERIOD)) u_tick
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick)
  );

  // Home sensor pin synchroniser
  logic home_meta;
  logic home_sync;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      home_meta <= 1'b0;
      home_sync <= 1'b0;
    end
    else
    begin
      home_meta <= home_sensor_pin;
      home_sync <= home_meta;
    end
  end

  // Warning and fault chain
  wire warning_now = |warn_conditions;
  logic warn_seen; // Warning delayed one cycle
  logic overload_alarm; // Sticky until overload ends
  wire fault_now = other_fault | warn_seen | overload_alarm;
  wire ready_now = drive_ready & ~fault_now & ~warning_now;

  // Warning-class faults reach the fault output one cycle after warning
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      warn_seen <= 1'b0;
    else
      warn_seen <= warning_now;
  end

  // Position completed, by mode
  wire [31:0] offset_mag = position_offset[31] ? 32'(-position_offset) : 32'(position_offset);
  wire pulse_in_band = (pulse_error <= position_tolerance);
  wire internal_in_band = (offset_mag <= {16'h0000, position_tolerance});
  wire position_done = (external_pulse_mode & pulse_in_band)
    | (internal_position_mode & internal_in_band);

  // Overload time accounting in ticks
  logic [15:0] overload_count; // Continuous overload ticks
  wire [31:0] scaled_count = 32'(overload_count) * 32'h00000064;
  wire [31:0] warn_limit = 32'(overload_time) * 32'(overload_warn_level);
  wire overload_warning = motor_overloaded && (scaled_count > warn_limit);
  wire overload_full = motor_overloaded && (overload_count > overload_time);

  // Count while overloaded, restart when load drops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      overload_count <= 16'h0000;
    else if (!motor_overloaded)
      overload_count <= 16'h0000;
    else if (tick && overload_count != 16'hFFFF)
      overload_count <= overload_count + 16'h0001;
  end

  // Alarm holds until overload condition clears
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      overload_alarm <= 1'b0;
    else if (overload_full)
      overload_alarm <= 1'b1;
    else if (!motor_overloaded)
      overload_alarm <= 1'b0;
  end

  // Internal command done after delay
  logic cmd_done;
  hold_timer u_cmd_timer
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .level(internal_cmd_finished),
    .delay(cmd_done_delay),
    .done(cmd_done)
  );

  // Brake release timing
  logic brake_on_done;
  logic brake_off_done;
  logic brake_release; // High while brake is released
  hold_timer u_brake_on
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .level(servo_on),
    .delay(brake_on_delay),
    .done(brake_on_done)
  );
  hold_timer u_brake_off
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .level(!servo_on),
    .delay(brake_off_delay),
    .done(brake_off_done)
  );

  // Release after on delay, engage after off delay
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      brake_release <= 1'b0;
    else if (brake_on_done)
      brake_release <= 1'b1;
    else if (brake_off_done)
      brake_release <= 1'b0;
  end

  // Homing completed
  wire homing_done = home_sync & homing_conditions_met;

  // Gather status functions by code
  always_comb
  begin
    func_state = '0;
    func_state[1] = ready_now;
    func_state[2] = control_power;
    func_state[3] = (motor_speed <= zero_speed_range);
    func_state[4] = (motor_speed >= target_speed_setting);
    func_state[5] = position_done;
    func_state[6] = torque_param_limit_hit | torque_analog_limit_hit;
    func_state[7] = fault_now;
    func_state[8] = brake_release;
    func_state[9] = homing_done;
    func_state[10] = overload_warning;
    func_state[11] = warning_now;
    func_state[12] = cmd_done;
  end

  // Register the selected function onto each slot
  generate
    for (genvar s = 0; s < SLOTS; s++)
    begin : g_slot
      wire [3:0] code = slot_select[s*CODE_W +: CODE_W];
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          output_slots[s] <= 1'b0;
        else
          output_slots[s] <= pick(code, func_state);
      end
    end
  endgenerate

  // Alarm indication for display logic
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      overload_alarm_code <= 1'b0;
    else
      overload_alarm_code <= overload_alarm;
  end

  // Interrupt events on rising edges
  logic [IRQ_W-1:0] event_level;
  logic [IRQ_W-1:0] event_prev;
  assign event_level = {cmd_done, homing_done, overload_alarm,
    overload_warning, warning_now, fault_now};
  wire [IRQ_W-1:0] event_rise = event_level & ~event_prev;

  // AXI write path
  logic [ADDR_W-1:0] aw_addr; // Held write address
  logic aw_held;
  logic [DATA_W-1:0] w_data; // Held write data
  logic [3:0] w_strb;
  logic w_held;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire [7:0] wa = aw_addr;
  wire wr_zero = do_write && (wa == OFS_ZERO_SPEED);
  wire wr_target = do_write && (wa == OFS_TARGET_SPEED);
  wire wr_tol = do_write && (wa == OFS_POS_TOL);
  wire wr_level = do_write && (wa == OFS_OVL_LEVEL);
  wire wr_otime = do_write && (wa == OFS_OVL_TIME);
  wire wr_cdelay = do_write && (wa == OFS_CMD_DELAY);
  wire wr_bon = do_write && (wa == OFS_BRAKE_ON);
  wire wr_boff = do_write && (wa == OFS_BRAKE_OFF);
  wire wr_slot = do_write && (wa == OFS_SLOT_SEL);
  wire wr_istat = do_write && (wa == OFS_IRQ_STATUS);
  wire wr_imask = do_write && (wa == OFS_IRQ_MASK);
  wire wr_ro = (wa == OFS_FUNC_STATE) || (wa == OFS_PINS);
  wire wr_hit = wr_zero | wr_target | wr_tol | wr_level | wr_otime | wr_cdelay
    | wr_bon | wr_boff | wr_slot | wr_istat | wr_imask;
  wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] wbits = w_data & wmask;

  // Capture address and data in either order, answer after both
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_hit || wr_ro) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration register writes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      zero_speed_range <= RST_ZERO_SPEED;
      target_speed_setting <= RST_TARGET_SPEED;
      position_tolerance <= RST_POS_TOL;
      overload_warn_level <= RST_OVL_LEVEL;
      overload_time <= RST_OVL_TIME;
      cmd_done_delay <= RST_CMD_DELAY;
      brake_on_delay <= RST_BRAKE_ON;
      brake_off_delay <= RST_BRAKE_OFF;
      slot_select <= RST_SLOT_SEL;
      irq_mask <= '0;
    end
    else
    begin
      // Lanes without a strobe keep their old bits
      if (wr_zero) zero_speed_range <= (zero_speed_range & ~wmask[15:0]) | wbits[15:0];
      if (wr_target)
        target_speed_setting <= (target_speed_setting & ~wmask[15:0]) | wbits[15:0];
      if (wr_tol) position_tolerance <= (position_tolerance & ~wmask[15:0]) | wbits[15:0];
      if (wr_level)
        overload_warn_level <= (overload_warn_level & ~wmask[7:0]) | wbits[7:0];
      if (wr_otime) overload_time <= (overload_time & ~wmask[15:0]) | wbits[15:0];
      if (wr_cdelay) cmd_done_delay <= (cmd_done_delay & ~wmask[15:0]) | wbits[15:0];
      if (wr_bon) brake_on_delay <= (brake_on_delay & ~wmask[15:0]) | wbits[15:0];
      if (wr_boff) brake_off_delay <= (brake_off_delay & ~wmask[15:0]) | wbits[15:0];
      if (wr_slot) slot_select <= (slot_select & ~wmask[19:0]) | wbits[19:0];
      if (wr_imask) irq_mask <= (irq_mask & ~wmask[IRQ_W-1:0]) | wbits[IRQ_W-1:0];
    end
  end

  // Sticky status: new event wins over write-one-to-clear
  wire [IRQ_W-1:0] irq_clear = wr_istat ? wbits[IRQ_W-1:0] : '0;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_status <= '0;
      event_prev <= '0;
      irq <= 1'b0;
    end
    else
    begin
      event_prev <= event_level;
      irq_status <= (irq_status & ~irq_clear) | event_rise;
      irq <= |(irq_status & irq_mask);
    end
  end

  // AXI read path, data one cycle after address
  wire [7:0] ra = s_axi_araddr;
  wire [31:0] rd_word =
    (ra == OFS_ZERO_SPEED) ? 32'(zero_speed_range) :
    (ra == OFS_TARGET_SPEED) ? 32'(target_speed_setting) :
    (ra == OFS_POS_TOL) ? 32'(position_tolerance) :
    (ra == OFS_OVL_LEVEL) ? 32'(overload_warn_level) :
    (ra == OFS_OVL_TIME) ? 32'(overload_time) :
    (ra == OFS_CMD_DELAY) ? 32'(cmd_done_delay) :
    (ra == OFS_BRAKE_ON) ? 32'(brake_on_delay) :
    (ra == OFS_BRAKE_OFF) ? 32'(brake_off_delay) :
    (ra == OFS_SLOT_SEL) ? 32'(slot_select) :
    (ra == OFS_FUNC_STATE) ? 32'({func_state, 1'b0}) :
    (ra == OFS_IRQ_STATUS) ? 32'(irq_status) :
    (ra == OFS_IRQ_MASK) ? 32'(irq_mask) :
    (ra == OFS_PINS) ? 32'(output_slots) : 32'h00000000;
  wire rd_hit = (ra <= OFS_PINS) && (ra[1:0] == 2'h0);
  assign s_axi_arready = !s_axi_rvalid;

  // Latch read answer and hold until taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule

// ===== hw/servo_dout_pkg.sv
package servo_dout_pkg;

  // System clock and slow tick
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;

  // Bus widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SLOTS = 5;
  localparam int unsigned CODE_W = 4;
  localparam int unsigned FUNCS = 12;
  localparam int unsigned IRQ_W = 6;

  // Register byte offsets
  localparam logic [7:0] OFS_ZERO_SPEED = 8'h00;
  localparam logic [7:0] OFS_TARGET_SPEED = 8'h04;
  localparam logic [7:0] OFS_POS_TOL = 8'h08;
  localparam logic [7:0] OFS_OVL_LEVEL = 8'h0C;
  localparam logic [7:0] OFS_OVL_TIME = 8'h10;
  localparam logic [7:0] OFS_CMD_DELAY = 8'h14;
  localparam logic [7:0] OFS_BRAKE_ON = 8'h18;
  localparam logic [7:0] OFS_BRAKE_OFF = 8'h1C;
  localparam logic [7:0] OFS_SLOT_SEL = 8'h20;
  localparam logic [7:0] OFS_FUNC_STATE = 8'h24;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h28;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h2C;
  localparam logic [7:0] OFS_PINS = 8'h30;

  // Reset values
  localparam logic [15:0] RST_ZERO_SPEED = 16'h000A;
  localparam logic [15:0] RST_TARGET_SPEED = 16'h0BB8;
  localparam logic [15:0] RST_POS_TOL = 16'h0063;
  localparam logic [7:0] RST_OVL_LEVEL = 8'h3C;
  localparam logic [15:0] RST_OVL_TIME = 16'h1F40;
  localparam logic [15:0] RST_CMD_DELAY = 16'h0000;
  localparam logic [15:0] RST_BRAKE_ON = 16'h0000;
  localparam logic [15:0] RST_BRAKE_OFF = 16'h0000;
  localparam logic [19:0] RST_SLOT_SEL = 20'h00000;

  // Output function codes
  localparam logic [3:0] FN_OFF = 4'h0;
  localparam logic [3:0] FN_LAST = 4'hC;

  // Interrupt bit positions
  localparam int unsigned IRQ_FAULT = 0;
  localparam int unsigned IRQ_WARN = 1;
  localparam int unsigned IRQ_OVL_WARN = 2;
  localparam int unsigned IRQ_OVL_ALARM = 3;
  localparam int unsigned IRQ_HOME = 4;
  localparam int unsigned IRQ_CMD_DONE = 5;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== hw/tick_divider.sv
`timescale 1ns/100ps
// One-cycle enable every PERIOD clocks
module tick_divider
#(
  parameter int unsigned PERIOD = 10000
)
(
  input wire logic aclk,
  input wire logic aresetn,
  output logic tick
);

  logic [31:0] count; // Cycles since last tick
  wire last = (count == 32'(PERIOD - 1));

  // Free-running counter, wraps at the period
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count <= 32'h00000000;
      tick <= 1'b0;
    end
    else
    begin
      count <= last ? 32'h00000000 : count + 32'h00000001;
      tick <= last;
    end
  end

endmodule

// ===== hw/hold_timer.sv
`timescale 1ns/100ps
// Output rises once the input has stayed high for delay ticks
module hold_timer
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic level,
  input wire logic [15:0] delay,
  output logic done
);

  logic [15:0] elapsed; // Ticks seen while level is high
  wire reached = (elapsed >= delay);

  // Count ticks while held, restart when the input drops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      elapsed <= 16'h0000;
      done <= 1'b0;
    end
    else if (!level)
    begin
      elapsed <= 16'h0000;
      done <= 1'b0;
    end
    else
    begin
      if (tick && !reached)
        elapsed <= elapsed + 16'h0001;
      done <= reached;
    end
  end

endmodule

// ===== verif/servo_status_output_mapper_sva.sv
`timescale 1ns/100ps
// Bus handshake and overload alarm checks on the mapper ports
module servo_status_output_mapper_sva
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic motor_overloaded,
  input wire logic overload_alarm_code
);
  // All checks share the system clock and its reset
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  chk_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped early");
  chk_read_turn: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_write_turn: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  chk_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during answer");
  chk_alarm_cause: assert property ($rose(overload_alarm_code) |-> $past(motor_overloaded, 2))
    else $error("alarm without overload");
  chk_alarm_clear: assert property (!motor_overloaded [*4] |-> !overload_alarm_code)
    else $error("alarm outlived overload");
endmodule

bind servo_status_output_mapper servo_status_output_mapper_sva u_sva
(
  .aclk,
  .aresetn,
  .s_axi_awvalid,
  .s_axi_awready,
  .s_axi_wvalid,
  .s_axi_wready,
  .s_axi_bvalid,
  .s_axi_bready,
  .s_axi_arvalid,
  .s_axi_arready,
  .s_axi_rvalid,
  .s_axi_rready,
  .motor_overloaded,
  .overload_alarm_code
);

// ===== verif/pin_reader_model.sv
`timescale 1ns/100ps
// Host controller that samples the status pins once per clock
module pin_reader_model
  import servo_dout_pkg::*;
(
  input wire logic aclk,
  input wire logic [SLOTS-1:0] pins,
  output logic [SLOTS-1:0] seen
);
  // Latch the pins on every rising edge
  always_ff @(posedge aclk)
  begin
    seen <= pins;
  end
endmodule

// ===== verif/servo_status_output_mapper_test.sv
`timescale 1ns/100ps
module servo_status_output_mapper_test
  import servo_dout_pkg::*;
;
  logic aclk = '0, aresetn = '0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic drive_ready = '0, control_power = '0, external_pulse_mode = '0;
  logic internal_position_mode = '0, torque_param_limit_hit = '0, torque_analog_limit_hit = '0;
  logic other_fault = '0, servo_on = '0, home_sensor_pin = '0, homing_conditions_met = '0;
  logic motor_overloaded = '0, internal_cmd_finished = '0;
  logic [15:0] motor_speed = '0, pulse_error = '0;
  logic signed [31:0] position_offset = '0;
  logic [4:0] warn_conditions = '0;
  logic [SLOTS-1:0] output_slots, seen;
  logic overload_alarm_code, irq;
  logic [19:0] sel;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  // Speeds on both sides of the default zero and target settings
  logic [15:0] sp_tab [6] = '{16'h0000, 16'h000A, 16'h000B, 16'h0BB7, 16'h0BB8, 16'h0BB9};
  // Reset values of the settings registers, offsets 00 to 20
  logic [31:0] rst_tab [9] = '{32'(RST_ZERO_SPEED), 32'(RST_TARGET_SPEED), 32'(RST_POS_TOL),
    32'(RST_OVL_LEVEL), 32'(RST_OVL_TIME), 32'(RST_CMD_DELAY), 32'(RST_BRAKE_ON),
    32'(RST_BRAKE_OFF), 32'(RST_SLOT_SEL)};

  // Short tick so delays take tens of cycles
  servo_status_output_mapper #(.TICK_PERIOD(10)) u_dut
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .drive_ready, .control_power, .motor_speed, .external_pulse_mode,
    .internal_position_mode, .pulse_error, .position_offset, .torque_param_limit_hit,
    .torque_analog_limit_hit, .other_fault, .warn_conditions, .servo_on, .home_sensor_pin,
    .homing_conditions_met, .motor_overloaded, .internal_cmd_finished, .output_slots,
    .overload_alarm_code, .irq
  );

  // Host reading the pins
  pin_reader_model u_host
  (
    .aclk,
    .pins(output_slots),
    .seen
  );

  // 10 MHz clock
  initial
  begin
    forever #50 aclk = ~aclk;
  end

  // Hang guard
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask

  // Write one word; awaits the response
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    check(32'(s_axi_bresp), 32'(er), "write response");
  endtask

  // Read one word; awaits the answer
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    s_axi_rready <= 1'h0;
    check(32'(s_axi_rresp), 32'(er), "read response");
  endtask

  // Expected pin level for a function code under default settings
  function automatic logic exp_fn(input logic [3:0] c);
    logic w;
    logic f;
    w = |warn_conditions;
    f = other_fault | w;
    case (c)
      4'h1: return drive_ready & !f;
      4'h2: return control_power;
      4'h3: return motor_speed <= RST_ZERO_SPEED;
      4'h4: return motor_speed >= RST_TARGET_SPEED;
      4'h5: return (external_pulse_mode && pulse_error <= RST_POS_TOL) || (internal_position_mode
        && position_offset <= int'(RST_POS_TOL) && position_offset >= -int'(RST_POS_TOL));
      4'h6: return torque_param_limit_hit | torque_analog_limit_hit;
      4'h7: return f;
      4'h8: return servo_on;
      4'h9: return home_sensor_pin & homing_conditions_met;
      4'hB: return w;
      4'hC: return internal_cmd_finished;
      default: return 1'h0;
    endcase
  endfunction

  initial
  begin
    void'($urandom(32'hC060C791));
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i < 9; i++)
    begin
      axi_rd(8'(i * 4), rd, RESP_OKAY);
      check(rd, rst_tab[i], "reset value");
    end
    axi_rd(8'h40, rd, RESP_SLVERR);
    axi_wr(8'h42, 32'h1, RESP_SLVERR);
    axi_wr(OFS_FUNC_STATE, 32'hFFF, RESP_OKAY);
    // Codes 1 to 15 first, then random codes; drive states random throughout
    for (int i = 0; i < 40; i++)
    begin
      for (int s = 0; s < SLOTS; s++)
        sel[4*s +: 4] = (i < 3) ? 4'((i * 5 + s + 1) % 16) : 4'($urandom_range(15));
      axi_wr(OFS_SLOT_SEL, {12'h000, sel}, RESP_OKAY);
      {drive_ready, control_power, external_pulse_mode, internal_position_mode,
        torque_param_limit_hit, torque_analog_limit_hit, other_fault, servo_on, home_sensor_pin,
        homing_conditions_met, internal_cmd_finished, warn_conditions} <= 16'($urandom);
      motor_speed <= $urandom_range(1) ? sp_tab[$urandom_range(5)] : 16'($urandom);
      pulse_error <= 16'($urandom_range(101, 97));
      position_offset <= 32'(int'($urandom_range(200)) - 100);
      repeat (30) @(posedge aclk);
      for (int s = 0; s < SLOTS; s++)
        check(32'(seen[s]), 32'(exp_fn(sel[4*s +: 4])), "slot");
    end
    other_fault <= 1'h0;
    warn_conditions <= 5'h00;
    servo_on <= 1'h0;
    internal_cmd_finished <= 1'h0;
    // Warning leads the fault by one cycle
    axi_wr(OFS_SLOT_SEL, 32'h0007B, RESP_OKAY);
    repeat (10) @(posedge aclk);
    warn_conditions <= 5'h04;
    for (int t = 0; t < 10 && !output_slots[0]; t++)
      @(posedge aclk);
    check(32'(output_slots), 32'h01, "fault not after warning");
    @(posedge aclk);
    check(32'(output_slots), 32'h03, "fault missing");
    warn_conditions <= 5'h00;
    // Overload, command delay and brake delay
    axi_wr(OFS_OVL_TIME, 32'h0000000A, RESP_OKAY);
    axi_wr(OFS_CMD_DELAY, 32'h00000003, RESP_OKAY);
    axi_wr(OFS_BRAKE_ON, 32'h00000004, RESP_OKAY);
    axi_wr(OFS_SLOT_SEL, 32'hB8C7A, RESP_OKAY);
    axi_wr(OFS_IRQ_STATUS, 32'h3F, RESP_OKAY);
    motor_overloaded <= 1'h1;
    internal_cmd_finished <= 1'h1;
    servo_on <= 1'h1;
    repeat (15) @(posedge aclk);
    check(32'(output_slots[3:2]), 32'h0, "delays too short");
    repeat (35) @(posedge aclk);
    check(32'(output_slots[2:0]), 32'h4, "warn early or cmd late");
    repeat (40) @(posedge aclk);
    check(32'(output_slots[3:0]), 32'hD, "warn or brake");
    repeat (60) @(posedge aclk);
    check({30'h0, overload_alarm_code, output_slots[1]}, 32'h3, "alarm");
    check(32'(irq), 32'h0, "masked irq");
    axi_wr(OFS_IRQ_MASK, 32'h8, RESP_OKAY);
    repeat (3) @(posedge aclk);
    check(32'(irq), 32'h1, "unmasked irq");
    axi_rd(OFS_IRQ_STATUS, rd, RESP_OKAY);
    check(32'(rd[IRQ_OVL_ALARM]), 32'h1, "alarm status");
    axi_wr(OFS_IRQ_STATUS, 32'h8, RESP_OKAY);
    repeat (3) @(posedge aclk);
    check(32'(irq), 32'h0, "cleared irq");
    motor_overloaded <= 1'h0;
    repeat (5) @(posedge aclk);
    check({31'h0, overload_alarm_code}, 32'h0, "alarm held");
    finish_test();
  end
endmodule
